// *** rtl/sss_pkg.sv ***
// Package with the constants, carrier types and behaviour list of the supervisor register set.
// Behaviour
// - A 32-bit access fault cause register records data access and alignment causes.
// - An alignment exception loads the fault address register with the element address.
// - A 64-bit free running count increments on every counter tick.
// - Free running count writes are taken only in supervisor mode.
// - High half is big-endian bits 0 to 31, low half bits 32 to 63.
// - Each half is its own 32-bit write target; the other half stays untouched.
// - Reading the countdown counter has no side effect on it.
// - A countdown write replaces the whole counter with the written value.
// - A zero to one change of countdown bit 0 raises a request, writes included.
// - Requests accumulate into one; taking the countdown exception cancels them all.
// - Tick comes from a divided processor clock, 1 MHz, or a selected external source.
// - Countdown counter has no reset and keeps counting while reset is asserted.
// - Countdown counter runs always, stopping only when its tick clock is turned off.
// - Any exception loads the resume address with the faulting or the following instruction.
// - A system call exception saves the address of the following instruction.
// - Status save takes exception information in bits 0 to 15, machine state in 16 to 31.
// - Return from exception restores machine state and resumes at the saved address.
// - Four 32-bit scratch registers are freely readable and writable without side effects.
// - Read-only identity register: version in bits 0 to 15, revision in 16 to 31.
// - All these special registers are reachable from supervisor mode only.
// - Strobe writes: 80 sets enable and recoverable, 81 clears enable and sets recoverable, 82 clears both.
// - Reading any strobe register raises a software emulation fault.
// - Countdown requests are held off while the interrupt enable bit is zero.
// - Machine state bit 30 is kept as the recoverable flag.
package sss_pkg;

  // Special register numbers as seen by the move-to and move-from operations.
  localparam logic [9:0] SPR_FAULT_CAUSE  = 10'h012;
  localparam logic [9:0] SPR_FAULT_ADDR   = 10'h013;
  localparam logic [9:0] SPR_COUNTDOWN    = 10'h016;
  localparam logic [9:0] SPR_RESUME_SAVE  = 10'h01a;
  localparam logic [9:0] SPR_STATUS_SAVE  = 10'h01b;
  localparam logic [9:0] SPR_IRQ_ON_REC   = 10'h050;
  localparam logic [9:0] SPR_IRQ_OFF_REC  = 10'h051;
  localparam logic [9:0] SPR_IRQ_OFF_UNR  = 10'h052;
  localparam logic [9:0] SPR_SCRATCH_0    = 10'h110;
  localparam logic [9:0] SPR_SCRATCH_3    = 10'h113;
  localparam logic [9:0] SPR_COUNT_LOW    = 10'h11c;
  localparam logic [9:0] SPR_COUNT_HIGH   = 10'h11d;
  localparam logic [9:0] SPR_CORE_ID      = 10'h11f;

  // Machine state low half holds big-endian bits 16 to 31, so bit n sits at index 31-n.
  localparam int unsigned MS_IRQ_EN_BIT   = 15;
  localparam int unsigned MS_USER_BIT     = 14;
  localparam int unsigned MS_RECOVER_BIT  = 1;
  localparam logic [15:0] MS_RESET        = 16'h0000;

  // Tick timing: the counter tick period and the processor clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS   = 100;
  localparam int unsigned TICK_PERIOD_NS  = 1000;
  localparam int unsigned TICK_DIV        = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  TICK_LAST       = 4'(TICK_DIV - 1);

  // Address step to the instruction after a faulting one.
  localparam logic [31:0] INSTR_STEP      = 32'h0000_0004;

  typedef enum logic [2:0] {
    EXC_OTHER,
    EXC_DATA_ACCESS,
    EXC_ALIGNMENT,
    EXC_SYSTEM_CALL,
    EXC_COUNTDOWN
  } sss_exc_kind_type;

  typedef enum logic [2:0] {
    CLS_NONE,
    CLS_RW,
    CLS_RO,
    CLS_WO,
    CLS_STROBE
  } sss_spr_class_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [9:0]  num;
    logic [31:0] data;
  } sss_spr_req_type;

  typedef struct packed {
    logic        done;
    logic        privFault;
    logic        emulFault;
    logic [31:0] data;
  } sss_spr_rsp_type;

  typedef struct packed {
    logic             take;
    sss_exc_kind_type kind;
    logic             nextSel;
    logic [31:0]      pc;
    logic [15:0]      info;
    logic [31:0]      cause;
    logic [31:0]      ea;
  } sss_exc_type;

endpackage

// *** rtl/sss_spr_set.sv ***
// Supervisor special register set: fault, save, scratch, identity, counters and strobes.
`timescale 1ns/1ns
module sss_spr_set #(
  parameter logic [15:0] VERSION_ID  = 16'h0a5a,  // Arbitrary value.
  parameter logic [15:0] REVISION_ID = 16'h0001   // Arbitrary value.
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire sss_pkg::sss_spr_req_type sprReq,
  output sss_pkg::sss_spr_rsp_type      sprRsp,
  input  wire sss_pkg::sss_exc_type     exc,
  input  wire logic                     rfiTake,
  input  wire logic                     msrWrite,
  input  wire logic [15:0]              msrWrData,
  output logic [15:0]                   machineState,
  output logic [31:0]                   resumeAddr,
  input  wire logic                     extClkSel,
  input  wire logic                     tickStop,
  input  wire logic                     extTickPin,
  output logic                          countdownIrq,
  output logic [31:0]                   countdownValue,
  output logic [63:0]                   freeRunningCount
);

  logic [31:0]                faultCause_ff;
  logic [31:0]                faultAddr_ff;
  logic [31:0]                countdown_ff;
  logic [31:0]                nxt_countdown;
  logic [31:0]                resumeSave_ff;
  logic [31:0]                statusSave_ff;
  logic [31:0]                scratch_ff [4];
  logic [31:0]                countHigh_ff;
  logic [31:0]                countLow_ff;
  logic [15:0]                machineState_ff;
  logic [15:0]                nxt_machineState;
  logic                       cdPending_ff;
  logic                       nxt_cdPending;
  logic [3:0]                 divCnt_ff;
  logic [3:0]                 nxt_divCnt;
  logic                       extTickMeta_ff;
  logic                       extTickSync_ff;
  logic                       extTickPrev_ff;
  logic                       tick;
  logic                       userMode;
  sss_pkg::sss_spr_class_type reqClass;
  logic                       wrOk;
  logic                       rdOk;
  logic                       badAccess;
  logic                       privAccess;
  logic [31:0]                rdMux;
  sss_pkg::sss_spr_rsp_type   sprRsp_ff;
  sss_pkg::sss_spr_rsp_type   nxt_sprRsp;

  // Access class of a special register number; used by both the read and write checks.
  function automatic sss_pkg::sss_spr_class_type sprClass(input logic [9:0] num);
    sss_pkg::sss_spr_class_type cls;
    cls = sss_pkg::CLS_NONE;
    if ((num == sss_pkg::SPR_FAULT_CAUSE) || (num == sss_pkg::SPR_FAULT_ADDR) ||
        (num == sss_pkg::SPR_COUNTDOWN) || (num == sss_pkg::SPR_RESUME_SAVE) ||
        (num == sss_pkg::SPR_STATUS_SAVE) ||
        ((num >= sss_pkg::SPR_SCRATCH_0) && (num <= sss_pkg::SPR_SCRATCH_3))) begin
      cls = sss_pkg::CLS_RW;
    end else if (num == sss_pkg::SPR_CORE_ID) begin
      cls = sss_pkg::CLS_RO;
    end else if ((num == sss_pkg::SPR_COUNT_LOW) || (num == sss_pkg::SPR_COUNT_HIGH)) begin
      cls = sss_pkg::CLS_WO;
    end else if ((num >= sss_pkg::SPR_IRQ_ON_REC) && (num <= sss_pkg::SPR_IRQ_OFF_UNR)) begin
      cls = sss_pkg::CLS_STROBE;
    end
    return cls;
  endfunction

  // True when an accepted write targets the given register number.
  function automatic logic writes(input logic ok, input logic [9:0] num, input logic [9:0] sel);
    return ok && (num == sel);
  endfunction

  // Privilege comes from the user-mode bit of the machine state kept here.
  assign userMode = machineState_ff[sss_pkg::MS_USER_BIT];
  assign reqClass = sprClass(sprReq.num);

  // Access checks: a wrong direction or unknown number is an emulation fault, user mode a
  // privilege fault; a faulting access changes nothing.
  always_comb begin
    rdOk       = 1'b0;
    wrOk       = 1'b0;
    badAccess  = 1'b0;
    privAccess = 1'b0;
    if (sprReq.valid) begin
      if (sprReq.write) begin
        badAccess = (reqClass == sss_pkg::CLS_NONE) || (reqClass == sss_pkg::CLS_RO);
      end else begin
        badAccess = (reqClass == sss_pkg::CLS_NONE) || (reqClass == sss_pkg::CLS_WO) ||
                    (reqClass == sss_pkg::CLS_STROBE);
      end
      privAccess = !badAccess && userMode;
      wrOk       = sprReq.write && !badAccess && !userMode;
      rdOk       = !sprReq.write && !badAccess && !userMode;
    end
  end

  // Read multiplexer; reading never disturbs any register.
  always_comb begin
    rdMux = 32'h0000_0000;
    case (sprReq.num)
      sss_pkg::SPR_FAULT_CAUSE: rdMux = faultCause_ff;
      sss_pkg::SPR_FAULT_ADDR:  rdMux = faultAddr_ff;
      sss_pkg::SPR_COUNTDOWN:   rdMux = countdown_ff;
      sss_pkg::SPR_RESUME_SAVE: rdMux = resumeSave_ff;
      sss_pkg::SPR_STATUS_SAVE: rdMux = statusSave_ff;
      sss_pkg::SPR_CORE_ID:     rdMux = {VERSION_ID, REVISION_ID};
      default: begin
        if ((sprReq.num >= sss_pkg::SPR_SCRATCH_0) && (sprReq.num <= sss_pkg::SPR_SCRATCH_3)) begin
          rdMux = scratch_ff[sprReq.num[1:0]];
        end
      end
    endcase
  end

  // Answer one cycle after the request, with data only for a good read.
  always_comb begin
    nxt_sprRsp.done      = sprReq.valid;
    nxt_sprRsp.privFault = privAccess;
    nxt_sprRsp.emulFault = sprReq.valid && badAccess;
    nxt_sprRsp.data      = rdOk ? rdMux : 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sprRsp_ff <= '0;
    end else begin
      sprRsp_ff <= nxt_sprRsp;
    end
  end

  // External tick pin: two flip-flops, then an edge detect on the settled copy.
  // No reset, so an external tick keeps the counters moving through reset.
  always_ff @(posedge clk) begin
    extTickMeta_ff <= extTickPin;
    extTickSync_ff <= extTickMeta_ff;
    extTickPrev_ff <= extTickSync_ff;
  end

  // Divider without reset so the tick keeps running during reset; an unknown start
  // value falls into the else branch and settles to zero on the first edge.
  always_comb begin
    if (divCnt_ff < sss_pkg::TICK_LAST) begin
      nxt_divCnt = divCnt_ff + 4'h1;
    end else begin
      nxt_divCnt = 4'h0;
    end
  end

  always_ff @(posedge clk) begin
    divCnt_ff <= nxt_divCnt;
  end

  // One tick feeds both counters; the clock-source select picks its origin.
  always_comb begin
    if (tickStop) begin
      tick = 1'b0;
    end else if (extClkSel) begin
      tick = extTickSync_ff && !extTickPrev_ff;
    end else begin
      tick = (divCnt_ff == sss_pkg::TICK_LAST);
    end
  end

  // Countdown next value: a write beats the decrement, and zero wraps to all ones.
  always_comb begin
    if (writes(wrOk, sprReq.num, sss_pkg::SPR_COUNTDOWN)) begin
      nxt_countdown = sprReq.data;
    end else if (tick) begin
      nxt_countdown = countdown_ff - 32'h0000_0001;
    end else begin
      nxt_countdown = countdown_ff;
    end
  end

  // The countdown counter has no reset at all and keeps counting through it.
  always_ff @(posedge clk) begin
    countdown_ff <= nxt_countdown;
  end

  // Big-endian bit 0 is index 31; a rising edge there, from a tick or a write, sets
  // the pending flag. Several rises merge into one; the countdown exception clears it,
  // but a rise in that same cycle wins.
  always_comb begin
    nxt_cdPending = (nxt_countdown[31] && !countdown_ff[31]) ||
                    (cdPending_ff && !(exc.take && (exc.kind == sss_pkg::EXC_COUNTDOWN)));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cdPending_ff <= 1'b0;
    end else begin
      cdPending_ff <= nxt_cdPending;
    end
  end

  // Free running count: halves written separately, only with supervisor access.
  // A write to the low half suppresses the carry into the high half that cycle.
  always_ff @(posedge clk) begin
    if (writes(wrOk, sprReq.num, sss_pkg::SPR_COUNT_LOW)) begin
      countLow_ff <= sprReq.data;
    end else if (tick) begin
      countLow_ff <= countLow_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (writes(wrOk, sprReq.num, sss_pkg::SPR_COUNT_HIGH)) begin
      countHigh_ff <= sprReq.data;
    end else if (tick && (countLow_ff == 32'hffff_ffff) &&
                 !writes(wrOk, sprReq.num, sss_pkg::SPR_COUNT_LOW)) begin
      countHigh_ff <= countHigh_ff + 32'h0000_0001;
    end
  end

  // Fault registers keep their content through reset and change on the faults.
  always_ff @(posedge clk) begin
    if (exc.take && ((exc.kind == sss_pkg::EXC_DATA_ACCESS) ||
                     (exc.kind == sss_pkg::EXC_ALIGNMENT))) begin
      faultCause_ff <= exc.cause;
    end else if (writes(wrOk, sprReq.num, sss_pkg::SPR_FAULT_CAUSE)) begin
      faultCause_ff <= sprReq.data;
    end
  end

  always_ff @(posedge clk) begin
    if (exc.take && (exc.kind == sss_pkg::EXC_ALIGNMENT)) begin
      faultAddr_ff <= exc.ea;
    end else if (writes(wrOk, sprReq.num, sss_pkg::SPR_FAULT_ADDR)) begin
      faultAddr_ff <= sprReq.data;
    end
  end

  // Save registers: no reset, since their content is undefined until an exception.
  always_ff @(posedge clk) begin
    if (exc.take) begin
      if ((exc.kind == sss_pkg::EXC_SYSTEM_CALL) || exc.nextSel) begin
        resumeSave_ff <= exc.pc + sss_pkg::INSTR_STEP;
      end else begin
        resumeSave_ff <= exc.pc;
      end
    end else if (writes(wrOk, sprReq.num, sss_pkg::SPR_RESUME_SAVE)) begin
      resumeSave_ff <= sprReq.data;
    end
  end

  always_ff @(posedge clk) begin
    if (exc.take) begin
      statusSave_ff <= {exc.info, machineState_ff};
    end else if (writes(wrOk, sprReq.num, sss_pkg::SPR_STATUS_SAVE)) begin
      statusSave_ff <= sprReq.data;
    end
  end

  // Scratch registers: plain storage for the operating system, no reset.
  always_ff @(posedge clk) begin
    if (wrOk && (sprReq.num >= sss_pkg::SPR_SCRATCH_0) &&
        (sprReq.num <= sss_pkg::SPR_SCRATCH_3)) begin
      scratch_ff[sprReq.num[1:0]] <= sprReq.data;
    end
  end

  // Machine state: exceptions drop to supervisor with interrupts off and state marked
  // unrecoverable; return restores it; strobes touch only the two bits, data ignored.
  always_comb begin
    nxt_machineState = machineState_ff;
    if (exc.take) begin
      nxt_machineState[sss_pkg::MS_IRQ_EN_BIT]  = 1'b0;
      nxt_machineState[sss_pkg::MS_USER_BIT]    = 1'b0;
      nxt_machineState[sss_pkg::MS_RECOVER_BIT] = 1'b0;
    end else if (rfiTake) begin
      nxt_machineState = statusSave_ff[15:0];
    end else if (msrWrite) begin
      nxt_machineState = msrWrData;
    end else if (wrOk && (reqClass == sss_pkg::CLS_STROBE)) begin
      nxt_machineState[sss_pkg::MS_IRQ_EN_BIT] =
        (sprReq.num == sss_pkg::SPR_IRQ_ON_REC);
      nxt_machineState[sss_pkg::MS_RECOVER_BIT] =
        (sprReq.num != sss_pkg::SPR_IRQ_OFF_UNR);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      machineState_ff <= sss_pkg::MS_RESET;
    end else begin
      machineState_ff <= nxt_machineState;
    end
  end

  // The request is held off, not lost, while interrupts are disabled.
  assign countdownIrq = cdPending_ff && machineState_ff[sss_pkg::MS_IRQ_EN_BIT];

  // Outputs. The high half leads the 64-bit count, matching big-endian bits 0 to 31.
  assign sprRsp           = sprRsp_ff;
  assign machineState     = machineState_ff;
  assign resumeAddr       = resumeSave_ff;
  assign countdownValue   = countdown_ff;
  assign freeRunningCount = {countHigh_ff, countLow_ff};

endmodule

// *** tb/sss_tick_source.sv ***
// Model of the external tick source that drives the countdown tick pin.
`timescale 1ns/1ns
module sss_tick_source (
  input  wire logic clk,
  input  wire logic enable,
  output logic      pin
);
  logic [1:0] phase_ff;

  // The pin toggles every fourth clock while enabled and rests low otherwise.
  // It is unrelated to the divider phase, so edges land anywhere in a tick period.
  always_ff @(posedge clk) begin
    phase_ff <= enable ? phase_ff + 2'h1 : 2'h0;
    if (!enable) begin
      pin <= 1'b0;
    end else if (phase_ff == 2'h3) begin
      pin <= !pin;
    end
  end
endmodule

// *** tb/sss_spr_set_props.sv ***
// Checker of the supervisor special register set, bound to its top module.
`timescale 1ns/1ns
module sss_spr_set_props (
  input wire logic                     clk,
  input wire logic                     rst_n,
  input wire sss_pkg::sss_spr_req_type sprReq,
  input wire sss_pkg::sss_spr_rsp_type sprRsp,
  input wire sss_pkg::sss_exc_type     exc,
  input wire logic                     rfiTake,
  input wire logic                     msrWrite,
  input wire logic [15:0]              msrWrData,
  input wire logic [15:0]              machineState,
  input wire logic [31:0]              resumeAddr,
  input wire logic                     extClkSel,
  input wire logic                     tickStop,
  input wire logic                     extTickPin,
  input wire logic                     countdownIrq,
  input wire logic [31:0]              countdownValue,
  input wire logic [63:0]              freeRunningCount
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // A supervisor write and a cycle free of higher-priority state updates.
  wire logic wr = sprReq.valid && sprReq.write && !machineState[14];
  wire logic quiet = !exc.take && !rfiTake && !msrWrite;

  done_after_req_a: assert property (sprReq.valid |=> sprRsp.done)
    else $error("request not answered next cycle");
  strobe_bits_a: assert property (wr && quiet && sprReq.num inside {10'h050, 10'h051, 10'h052}
    |=> {machineState[15], machineState[1]} == ($past(sprReq.num) == 10'h050 ? 2'h3 :
        $past(sprReq.num) == 10'h051 ? 2'h1 : 2'h0))
    else $error("strobe write gave wrong enable bits");
  countdown_load_a: assert property (wr && sprReq.num == sss_pkg::SPR_COUNTDOWN
    |=> countdownValue == $past(sprReq.data)) else $error("countdown write not loaded");
  countdown_hold_a: assert property (tickStop [*2] ##0 !wr |=> $stable(countdownValue))
    else $error("countdown moved with ticks off");
  irq_rise_a: assert property ($rose(countdownValue[31]) && machineState[15] && !exc.take
    |-> ##[1:2] (countdownIrq || !machineState[15] || $past(exc.take)))
    else $error("no countdown request after bit rise");
  irq_masked_a: assert property (!machineState[15] && !$past(machineState[15])
    |-> !countdownIrq) else $error("countdown request while disabled");
  strobe_read_a: assert property (sprReq.valid && !sprReq.write && !machineState[14]
    && sprReq.num inside {10'h050, 10'h051, 10'h052} |=> sprRsp.emulFault)
    else $error("strobe read not faulted");
  user_refused_a: assert property (sprReq.valid && machineState[14]
    && sprReq.num inside {[sss_pkg::SPR_SCRATCH_0:sss_pkg::SPR_SCRATCH_3]} |=> sprRsp.privFault)
    else $error("user access not refused");
  exc_resume_a: assert property (exc.take |=> resumeAddr == (($past(exc.nextSel)
    || $past(exc.kind) == sss_pkg::EXC_SYSTEM_CALL) ? $past(exc.pc) + sss_pkg::INSTR_STEP
    : $past(exc.pc))) else $error("wrong resume address");
  high_half_a: assert property (wr && !exc.take && sprReq.num == sss_pkg::SPR_COUNT_HIGH
    |=> freeRunningCount[63:32] == $past(sprReq.data)) else $error("high half not loaded");
endmodule

bind sss_spr_set sss_spr_set_props i_sss_spr_set_props (.clk(clk), .rst_n(rst_n),
  .sprReq(sprReq), .sprRsp(sprRsp), .exc(exc), .rfiTake(rfiTake), .msrWrite(msrWrite),
  .msrWrData(msrWrData), .machineState(machineState), .resumeAddr(resumeAddr),
  .extClkSel(extClkSel), .tickStop(tickStop), .extTickPin(extTickPin),
  .countdownIrq(countdownIrq), .countdownValue(countdownValue),
  .freeRunningCount(freeRunningCount));

// *** tb/test_supervisor_spr_set.sv ***
// Self-checking testbench of the supervisor special register set.
`timescale 1ns/1ns
module test_supervisor_spr_set;
  logic clk, rst_n, rfiTake, msrWrite, extClkSel, tickStop, extTickPin, countdownIrq, srcEn;
  logic [15:0] msrWrData, machineState;
  logic [31:0] resumeAddr, countdownValue, seed, v, d, pc, s0;
  logic [63:0] freeRunningCount, base;
  sss_pkg::sss_spr_req_type req;
  sss_pkg::sss_spr_rsp_type rsp, got;
  sss_pkg::sss_exc_type excIn;
  int err_total, comparisons, cycles, edges;
  logic [9:0] rwNums [8] = '{10'h012, 10'h013, 10'h01a, 10'h01b, 10'h110, 10'h111, 10'h112, 10'h113};

  sss_spr_set i_sss_spr_set (.clk(clk), .rst_n(rst_n), .sprReq(req), .sprRsp(rsp), .exc(excIn),
    .rfiTake(rfiTake), .msrWrite(msrWrite), .msrWrData(msrWrData), .machineState(machineState),
    .resumeAddr(resumeAddr), .extClkSel(extClkSel), .tickStop(tickStop),
    .extTickPin(extTickPin), .countdownIrq(countdownIrq), .countdownValue(countdownValue),
    .freeRunningCount(freeRunningCount));
  sss_tick_source i_sss_tick_source (.clk(clk), .enable(srcEn), .pin(extTickPin));

  always #50 clk = ~clk;
  always @(posedge extTickPin) edges++;
  // A hang is cut short well past the few hundred cycles the sequence needs.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_total++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Enable and recoverable bits expected after each strobe register.
  function automatic logic [1:0] strobeBits(int i);
    return (i == 0) ? 2'h3 : (i == 1) ? 2'h1 : 2'h0;
  endfunction

  task automatic cmpVal(input logic [63:0] g, input logic [63:0] e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmpFlag(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One pulsed access; the registered answer stands only in the cycle after taking,
  // so it is sampled at the next falling edge before the strobe is dropped.
  task automatic spr(input logic w, input logic [9:0] n, input logic [31:0] dat);
    @(negedge clk);
    req = '{valid: 1'b1, write: w, num: n, data: dat};
    @(negedge clk);
    got = rsp;
    req.valid = 1'b0;
  endtask
  task automatic raise(input sss_pkg::sss_exc_kind_type k, input logic [31:0] a);
    @(negedge clk);
    excIn = '{take: 1'b1, kind: k, nextSel: 1'b0, pc: a, info: 16'h5a3c, cause: rnd(), ea: rnd()};
    @(negedge clk);
    excIn.take = 1'b0;
  endtask
  task automatic machine_state(input logic [15:0] m);
    @(negedge clk);
    msrWrData = m;
    msrWrite = 1'b1;
    @(negedge clk);
    msrWrite = 1'b0;
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0; rst_n = 1'b0; req = '0; excIn = '0; rfiTake = 1'b0; msrWrite = 1'b0;
    msrWrData = 16'h0000; extClkSel = 1'b0; tickStop = 1'b1; srcEn = 1'b0; seed = 32'h00010eac;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    // Plain read/write registers with random data.
    foreach (rwNums[i]) begin
      d = rnd();
      spr(1'b1, rwNums[i], d);
      spr(1'b0, rwNums[i], 32'h0);
      cmpVal(got.data, d);
    end
    s0 = d;
    spr(1'b0, sss_pkg::SPR_CORE_ID, 32'h0);
    cmpVal(got.data, {16'h0a5a, 16'h0001});
    spr(1'b1, sss_pkg::SPR_CORE_ID, rnd());
    cmpFlag(got.emulFault, 1'b1);
    for (int i = 0; i < 3; i++) begin
      spr(1'b0, 10'(sss_pkg::SPR_IRQ_ON_REC + i), 32'h0);
      cmpFlag(got.emulFault, 1'b1);
      spr(1'b1, 10'(sss_pkg::SPR_IRQ_ON_REC + i), rnd());
      cmpVal({machineState[15], machineState[1]}, strobeBits(i));
    end
    // Countdown and both count halves loaded with ticks off, then run for 100 clocks.
    v = rnd();
    spr(1'b1, sss_pkg::SPR_COUNTDOWN, v);
    spr(1'b0, sss_pkg::SPR_COUNTDOWN, 32'h0);
    spr(1'b0, sss_pkg::SPR_COUNTDOWN, 32'h0);
    cmpVal(got.data, v);
    d = rnd();
    spr(1'b1, sss_pkg::SPR_COUNT_LOW, rnd());
    spr(1'b1, sss_pkg::SPR_COUNT_HIGH, d);
    base = {d, rnd()};
    spr(1'b1, sss_pkg::SPR_COUNT_LOW, base[31:0]);
    cmpVal(freeRunningCount, base);
    tickStop = 1'b0;
    repeat (100) @(negedge clk);
    tickStop = 1'b1;
    repeat (2) @(negedge clk);
    cmpFlag((freeRunningCount - base) inside {[9:11]}, 1'b1);
    cmpVal(32'(v - countdownValue), freeRunningCount - base);
    // Wrap through zero and a software rise of the top bit both raise a request.
    spr(1'b1, sss_pkg::SPR_IRQ_ON_REC, 32'h0);
    spr(1'b1, sss_pkg::SPR_COUNTDOWN, 32'h0);
    tickStop = 1'b0;
    repeat (25) @(negedge clk);
    tickStop = 1'b1;
    cmpFlag(countdownIrq, 1'b1);
    raise(sss_pkg::EXC_COUNTDOWN, rnd());
    spr(1'b1, sss_pkg::SPR_IRQ_ON_REC, 32'h0);
    cmpFlag(countdownIrq, 1'b0);
    spr(1'b1, sss_pkg::SPR_COUNTDOWN, 32'h0);
    spr(1'b1, sss_pkg::SPR_COUNTDOWN, 32'h8000_0000);
    cmpFlag(countdownIrq, 1'b1);
    // Alignment fault, return, then a system call.
    machine_state(16'h8002);
    pc = rnd() & 32'hffff_fffc;
    raise(sss_pkg::EXC_ALIGNMENT, pc);
    cmpVal(resumeAddr, pc);
    spr(1'b0, sss_pkg::SPR_FAULT_ADDR, 32'h0);
    cmpVal(got.data, excIn.ea);
    spr(1'b0, sss_pkg::SPR_FAULT_CAUSE, 32'h0);
    cmpVal(got.data, excIn.cause);
    spr(1'b0, sss_pkg::SPR_STATUS_SAVE, 32'h0);
    cmpVal(got.data, {16'h5a3c, 16'h8002});
    @(negedge clk);
    rfiTake = 1'b1;
    @(negedge clk);
    rfiTake = 1'b0;
    cmpVal(machineState, 16'h8002);
    raise(sss_pkg::EXC_SYSTEM_CALL, pc);
    cmpVal(resumeAddr, pc + 32'h4);
    // User mode refuses scratch and count writes.
    machine_state(16'h4000);
    spr(1'b1, sss_pkg::SPR_SCRATCH_3, rnd());
    cmpFlag(got.privFault, 1'b1);
    spr(1'b1, sss_pkg::SPR_COUNT_HIGH, ~d);
    cmpVal(freeRunningCount[63:32], d);
    machine_state(16'h0000);
    spr(1'b0, sss_pkg::SPR_SCRATCH_3, 32'h0);
    cmpVal(got.data, s0);
    // External tick source counts its own rising edges.
    v = rnd();
    spr(1'b1, sss_pkg::SPR_COUNTDOWN, v);
    extClkSel = 1'b1;
    tickStop = 1'b0;
    edges = 0;
    srcEn = 1'b1;
    repeat (64) @(negedge clk);
    srcEn = 1'b0;
    repeat (8) @(negedge clk);
    cmpVal(countdownValue, v - 32'(edges));
    tally_and_finish();
  end
endmodule
